// ---- mtb_partner.sv ----
module mtb_partner (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // time base outputs
  input wire logic count_down_flag,
  input wire logic time_base_event,
  // observations
  output int events,
  output logic seen_down
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      events <= 0;
      seen_down <= 1'b0;
    end else begin
      if (time_base_event)
        events <= events + 1;
      if (count_down_flag)
        seen_down <= 1'b1;
    end
  end
endmodule : mtb_partner

// ---- mtb_pkg.sv ----
package mtb_pkg;
  // ==========================================================
  // register offsets (word index on the plain register port)
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h1;
  localparam logic [3:0] ADDR_PERIOD = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  // ==========================================================
  // control field positions
  localparam int CTL_ON_BIT = 15;
  localparam int CTL_OPS_LSB = 4;
  localparam int CTL_CKPS_LSB = 2;
  localparam int CTL_MODE_LSB = 0;
  // ==========================================================
  // interrupt status bits
  localparam int IRQ_EVENT_BIT = 0;
  localparam int IRQ_MATCH_BIT = 1;
  localparam int IRQ_ZERO_BIT = 2;
  localparam int IRQ_BITS = 3;
  // ==========================================================
  // reset values
  localparam logic [14:0] COUNT_RESET = 15'h0000;
  localparam logic [14:0] PERIOD_RESET = 15'h0000;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [3:0] OPS_RESET = 4'h0;
  localparam logic [1:0] CKPS_RESET = 2'h0;
  // counter input is a quarter of the oscillator
  localparam logic [1:0] QUARTER_DIV = 2'h3;
  // ==========================================================
  // counting modes
  typedef enum logic [1:0] {
    MTB_FREE = 2'b00,
    MTB_SINGLE = 2'b01,
    MTB_UPDOWN = 2'b10,
    MTB_DOUBLE = 2'b11
  } mtb_mode_e;
endpackage : mtb_pkg

// ---- mtb_time_base.sv ----
// Summary of operation
// - a 15-bit counter, clocked through a prescaler, free-running and up/down events go through a postscaler.
// - bit 15 of the count register reads the direction, 1 while counting down.
// - the on bit starts and stops counting; clearing it keeps the count.
// - on count equal to period the counter wraps to zero or reverses at the next tick.
// - a zero period stops the counter and suppresses every event.
// - a zero active period is not replaced until the time base is turned off.
// - a 2-bit mode field picks free-running, single-shot, up/down or double update.
// - interrupt events depend on the mode and, in free-running and up/down only, on the 4-bit postscale field.
// - free-running counts up to period, wraps to zero, repeats while on.
// - free-running raises an event per wrap, divided by the postscaler.
// - single-shot counts once, wraps to zero and hardware clears the on bit.
// - single-shot gives exactly one event, postscaler ignored.
// - up/down mode raises an event at zero turning up, divided by the postscaler.
// - double update raises events at zero and at period match, no postscaler.
// - the counter clock is the quarter rate divided by 1, 4, 16 or 64.
module mtb_time_base (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // to duty comparators
  output logic [14:0] time_base_count,
  output logic count_down_flag,
  output logic period_match,
  output logic count_zero,
  output logic time_base_event,
  // interrupt
  output logic irq
);

  // ==========================================================
  // registers
  logic time_base_on;
  logic [1:0] count_mode_select;
  logic [1:0] input_prescale;
  logic [3:0] output_postscale;
  logic [14:0] period_value;
  logic [14:0] period_buffer;
  logic [1:0] quarter_cnt;
  logic [5:0] pre_cnt;
  logic [3:0] post_cnt;
  localparam int IRQ_BITS_W = mtb_pkg::IRQ_BITS;
  logic [IRQ_BITS_W-1:0] irq_status;
  logic [IRQ_BITS_W-1:0] irq_mask;

  // one address decode shared by every write enable
  function automatic logic reg_hit(input logic wr, input logic [3:0] addr,
                                   input logic [3:0] want);
    reg_hit = wr && addr == want;
  endfunction : reg_hit

  logic wr_ctl;
  logic wr_cnt;
  logic wr_per;
  logic wr_sts;
  logic wr_msk;
  assign wr_ctl = reg_hit(reg_write, reg_addr, mtb_pkg::ADDR_CONTROL);
  assign wr_cnt = reg_hit(reg_write, reg_addr, mtb_pkg::ADDR_COUNT);
  assign wr_per = reg_hit(reg_write, reg_addr, mtb_pkg::ADDR_PERIOD);
  assign wr_sts = reg_hit(reg_write, reg_addr, mtb_pkg::ADDR_IRQ_STATUS);
  assign wr_msk = reg_hit(reg_write, reg_addr, mtb_pkg::ADDR_IRQ_MASK);

  function automatic logic [5:0] prescale_last(input logic [1:0] sel);
    case (sel)
      2'h0: prescale_last = 6'h00;
      2'h1: prescale_last = 6'h03;
      2'h2: prescale_last = 6'h0f;
      default: prescale_last = 6'h3f;
    endcase
  endfunction : prescale_last

  // ==========================================================
  // clock dividers: quarter rate, then selectable prescaler
  // quarter divider runs free; writes only restart the prescaler
  logic quarter_tick;
  logic tick;
  assign quarter_tick = quarter_cnt == mtb_pkg::QUARTER_DIV;
  assign tick = quarter_tick && pre_cnt == prescale_last(input_prescale);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      quarter_cnt <= 2'h0;
    end else begin
      quarter_cnt <= quarter_cnt + 2'h1;
    end
  end

  // prescaler restarts on a count or control write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= 6'h00;
    end else if (wr_ctl || wr_cnt || !time_base_on) begin
      pre_cnt <= 6'h00;
    end else if (tick) begin
      pre_cnt <= 6'h00;
    end else if (quarter_tick) begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end

  // ==========================================================
  // counter core
  logic at_match;
  logic at_zero_turn;
  logic run;
  logic [14:0] count;
  logic down;
  mtb_pkg::mtb_mode_e mode;
  assign mode = mtb_pkg::mtb_mode_e'(count_mode_select);
  assign run = time_base_on && period_value != 15'h0000 && tick;
  assign at_match = run && count == period_value;
  // zero reached while counting down, about to turn up
  assign at_zero_turn = run && down && count == 15'h0001;
  logic updown;
  assign updown = mode == mtb_pkg::MTB_UPDOWN || mode == mtb_pkg::MTB_DOUBLE;
  // period of one must be avoided in up/down: count would step below zero

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= mtb_pkg::COUNT_RESET;
      down <= 1'b0;
    end else if (wr_cnt) begin
      count <= reg_wdata[14:0];
      down <= 1'b0;
    end else if (run) begin
      if (updown) begin
        if (at_match && !down) begin
          down <= 1'b1;
          count <= count - 15'h0001;
        end else if (down) begin
          count <= count - 15'h0001;
          if (count == 15'h0001) begin
            down <= 1'b0;
          end
        end else begin
          count <= count + 15'h0001;
        end
      end else if (at_match) begin
        count <= 15'h0000;
        down <= 1'b0;
      end else begin
        count <= count + 15'h0001;
      end
    end
  end

  // ==========================================================
  // control register; hardware clears on bit in single-shot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      time_base_on <= 1'b0;
      count_mode_select <= mtb_pkg::MODE_RESET;
      input_prescale <= mtb_pkg::CKPS_RESET;
      output_postscale <= mtb_pkg::OPS_RESET;
    end else begin
      if (wr_ctl) begin
        time_base_on <= reg_wdata[mtb_pkg::CTL_ON_BIT];
        count_mode_select <= reg_wdata[mtb_pkg::CTL_MODE_LSB +: 2];
        input_prescale <= reg_wdata[mtb_pkg::CTL_CKPS_LSB +: 2];
        output_postscale <= reg_wdata[mtb_pkg::CTL_OPS_LSB +: 4];
      end
      // hardware clear wins: the shot is over
      if (at_match && mode == mtb_pkg::MTB_SINGLE) begin
        time_base_on <= 1'b0;
      end
    end
  end

  // ==========================================================
  // period: buffered, loaded at wrap/zero or while off
  logic per_load;
  assign per_load = !time_base_on ||
    (!updown && at_match) || (updown && at_zero_turn);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      period_buffer <= mtb_pkg::PERIOD_RESET;
      period_value <= mtb_pkg::PERIOD_RESET;
    end else begin
      if (wr_per) begin
        period_buffer <= reg_wdata[14:0];
      end
      // a zero active period only changes once the time base is off
      if (per_load && (period_value != 15'h0000 || !time_base_on)) begin
        period_value <= wr_per ? reg_wdata[14:0] : period_buffer;
      end
    end
  end

  // ==========================================================
  // event generation with postscaler
  logic raw_event;
  logic post_event;
  logic use_post;
  logic post_done;
  always_comb begin
    raw_event = 1'b0;
    use_post = 1'b0;
    case (mode)
      mtb_pkg::MTB_FREE: begin
        raw_event = !updown && at_match;
        use_post = 1'b1;
      end
      mtb_pkg::MTB_SINGLE: begin
        raw_event = at_match;
      end
      mtb_pkg::MTB_UPDOWN: begin
        raw_event = at_zero_turn;
        use_post = 1'b1;
      end
      mtb_pkg::MTB_DOUBLE: begin
        raw_event = at_zero_turn || (at_match && !down);
      end
      default: begin
        raw_event = 1'b0;
      end
    endcase
  end
  assign post_done = post_cnt == output_postscale;
  assign post_event = raw_event && (!use_post || post_done);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt <= 4'h0;
    end else if (wr_ctl || wr_cnt) begin
      post_cnt <= 4'h0;
    end else if (raw_event && use_post) begin
      post_cnt <= post_done ? 4'h0 : post_cnt + 4'h1;
    end
  end

  // ==========================================================
  // outputs to comparators, all registered
  // pulses land with the count step, one clock after the match, traded for clean flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      period_match <= 1'b0;
      count_zero <= 1'b0;
      time_base_event <= 1'b0;
    end else begin
      period_match <= at_match;
      count_zero <= at_zero_turn || (!updown && at_match);
      time_base_event <= post_event;
    end
  end
  assign time_base_count = count;
  assign count_down_flag = down;

  // ==========================================================
  // interrupt status: write one to clear, set wins
  logic [IRQ_BITS_W-1:0] irq_set;
  assign irq_set = {count_zero, period_match, time_base_event};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq_mask <= '0;
    end else begin
      irq_status <= (irq_status &
        ~(wr_sts ? reg_wdata[IRQ_BITS_W-1:0] : '0)) | irq_set;
      if (wr_msk) begin
        irq_mask <= reg_wdata[IRQ_BITS_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_status | irq_set) & irq_mask);
    end
  end

  // ==========================================================
  // read port, data in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      case (reg_addr)
        mtb_pkg::ADDR_CONTROL:
          reg_rdata <= {time_base_on, 7'h00, output_postscale,
                        input_prescale, count_mode_select};
        mtb_pkg::ADDR_COUNT: reg_rdata <= {down, count};
        mtb_pkg::ADDR_PERIOD: reg_rdata <= {1'b0, period_buffer};
        mtb_pkg::ADDR_IRQ_STATUS:
          reg_rdata <= {13'h0000, irq_status};
        mtb_pkg::ADDR_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : mtb_time_base

// ---- mtb_time_base_asserts.sv ----
module mtb_time_base_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // time base outputs
  input wire logic [14:0] time_base_count,
  input wire logic count_down_flag,
  input wire logic period_match,
  input wire logic count_zero,
  input wire logic time_base_event,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // properties
  property p_rd_count;
    reg_read && reg_addr == mtb_pkg::ADDR_COUNT |=>
      reg_rdata == {$past(count_down_flag), $past(time_base_count)};
  endproperty
  // a landed write may load any count, so it is excused
  property p_step_up;
    !$past(reg_write) && !count_down_flag && !$past(count_down_flag)
      && $changed(time_base_count) |->
      time_base_count == $past(time_base_count) + 15'h0001
      || time_base_count == 15'h0000;
  endproperty
  property p_step_down;
    !$past(reg_write) && count_down_flag && $past(count_down_flag)
      && $changed(time_base_count) |->
      time_base_count == $past(time_base_count) - 15'h0001;
  endproperty
  property p_gap;
    $changed(time_base_count) && !$past(reg_write) |=>
      ($past(reg_write) || $stable(time_base_count)) [*3];
  endproperty
  property p_ev_pulse;
    time_base_event |=> !time_base_event;
  endproperty
  property p_match_pulse;
    period_match |=> !period_match;
  endproperty
  property p_zero_pulse;
    count_zero |=> !count_zero;
  endproperty
  property p_irq_off;
    reg_write && reg_addr == mtb_pkg::ADDR_IRQ_MASK
      && reg_wdata[2:0] == 3'h0 |-> ##2 !irq;
  endproperty
  // ==========================================================
  // assertions and covers
  a_rd_count: assert property (p_rd_count)
    else $error("count read data wrong");
  a_step_up: assert property (p_step_up)
    else $error("upward step wrong");
  a_step_down: assert property (p_step_down)
    else $error("downward step wrong");
  a_gap: assert property (p_gap)
    else $error("count ticks too fast");
  a_ev_pulse: assert property (p_ev_pulse)
    else $error("event longer than one cycle");
  a_match_pulse: assert property (p_match_pulse)
    else $error("match longer than one cycle");
  a_zero_pulse: assert property (p_zero_pulse)
    else $error("zero longer than one cycle");
  a_irq_off: assert property (p_irq_off)
    else $error("irq high with mask clear");
  c_event: cover property (time_base_event);
  c_down: cover property ($rose(count_down_flag));
  c_irq: cover property ($rose(irq));
endmodule : mtb_time_base_asserts

bind mtb_time_base mtb_time_base_asserts i_chk (.clock, .rst_n,
  .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .time_base_count, .count_down_flag, .period_match, .count_zero,
  .time_base_event, .irq);

// ---- mtb_time_base_tb_top.sv ----
module mtb_time_base_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata, rv;
  logic [14:0] time_base_count;
  logic count_down_flag, period_match, count_zero, time_base_event, irq;
  logic seen_down;
  int events, p, g, t0, t1, ev0;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'h28f4;
  always #5 clock = ~clock;
  mtb_time_base i_dut (.clock, .rst_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .time_base_count,
    .count_down_flag, .period_match, .count_zero, .time_base_event, .irq);
  mtb_partner i_far (.clock, .rst_n, .count_down_flag,
    .time_base_event, .events, .seen_down);
  // ==========================================================
  // tasks
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    // data stand only in the cycle after the strobe
    @(posedge clock);
    rv = reg_rdata;
  endtask : rd
  function automatic logic [15:0] ctl(input int on, ops, ck, m);
    return {1'(on), 7'h00, 4'(ops), 2'(ck), 2'(m)};
  endfunction : ctl
  // reference model: clocks between the first two events after cfg
  function automatic int exp_gap(input int m, ck, ops, per);
    int tk;
    tk = 4 * (1 << (2 * ck));
    case (m)
      0: exp_gap = tk * (per + 1) * (ops + 1);
      2: exp_gap = tk * 2 * per * (ops + 1);
      3: exp_gap = tk * (per - 1);
      default: exp_gap = 0;
    endcase
  endfunction : exp_gap
  // period is loaded from its buffer while the time base is off
  task cfg(input int m, ck, ops, per);
    wr(mtb_pkg::ADDR_CONTROL, 16'h0000);
    wr(mtb_pkg::ADDR_COUNT, 16'h0000);
    wr(mtb_pkg::ADDR_PERIOD, 16'(per));
    wr(mtb_pkg::ADDR_CONTROL, ctl(1, ops, ck, m));
  endtask : cfg
  task wev(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (time_base_event !== 1'b1 && n < 4000);
    t = n;
  endtask : wev
  task run(input int m, ck, ops, per, output int gap);
    cfg(m, ck, ops, per);
    wev(t0);
    wev(t1);
    gap = t1;
  endtask : run
  // ==========================================================
  // scenarios
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 10; a++) begin
      rd(4'(a));
      chk(rv, 0);
    end
    for (int c = 0; c < 4; c++) begin
      p = 1 + ($unsigned($random(seed)) % 6);
      run(0, c, 3 - c, p, g);
      chk(g, exp_gap(0, c, 3 - c, p));
    end
    wr(mtb_pkg::ADDR_CONTROL, 16'h0000);
    wr(mtb_pkg::ADDR_COUNT, 16'h0007);
    wr(mtb_pkg::ADDR_PERIOD, 16'h0014);
    wr(mtb_pkg::ADDR_CONTROL, ctl(1, 0, 3, 0));
    wr(mtb_pkg::ADDR_CONTROL, 16'h0000);
    repeat (30) @(posedge clock);
    rd(mtb_pkg::ADDR_COUNT);
    chk(rv, 16'h0007);
    ev0 = events;
    cfg(1, 0, 5, 2);
    wev(t0);
    repeat (60) @(posedge clock);
    chk(events - ev0, 1);
    rd(mtb_pkg::ADDR_CONTROL);
    chk(rv[15], 1'b0);
    rd(mtb_pkg::ADDR_COUNT);
    chk(rv, 0);
    run(2, 0, 1, 3, g);
    chk(g, exp_gap(2, 0, 1, 3));
    chk(seen_down, 1'b1);
    run(3, 0, 7, 4, g);
    chk(g, exp_gap(3, 0, 7, 4));
    cfg(0, 0, 0, 0);
    ev0 = events;
    repeat (60) @(posedge clock);
    chk(events - ev0, 0);
    wr(mtb_pkg::ADDR_PERIOD, 16'h0005);
    repeat (60) @(posedge clock);
    chk(events - ev0, 0);
    // once off, the buffered period is taken and the base runs again
    wr(mtb_pkg::ADDR_CONTROL, 16'h0000);
    wr(mtb_pkg::ADDR_CONTROL, ctl(1, 0, 0, 0));
    wev(t0);
    chk({period_match, count_zero}, 2'b11);
    wev(g);
    chk(g, exp_gap(0, 0, 0, 5));
    wr(mtb_pkg::ADDR_CONTROL, 16'h0000);
    rd(mtb_pkg::ADDR_IRQ_STATUS);
    chk(rv[0], 1'b1);
    chk(rv[2:1], 2'h3);
    chk(irq, 1'b0);
    wr(mtb_pkg::ADDR_IRQ_MASK, 16'h0001);
    repeat (3) @(posedge clock);
    chk(irq, 1'b1);
    wr(mtb_pkg::ADDR_IRQ_STATUS, 16'h0007);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    wr(mtb_pkg::ADDR_IRQ_MASK, 16'h0000);
    rd(mtb_pkg::ADDR_IRQ_STATUS);
    chk(rv, 0);
    print_verdict;
  end
  // hang guard, well above the longest expected run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      print_verdict;
    end
  end
endmodule : mtb_time_base_tb_top
